/* File: rtl/pcl_defs.svh */
// Constants of the panel link configuration and cycle timing block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef PCL_DEFS_SVH
`define PCL_DEFS_SVH

// ----------------------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------------------
`define PCL_CLK_PERIOD_NS 8
`define PCL_MS_NS         1000000
`define PCL_CYC_PER_MS    (`PCL_MS_NS / `PCL_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Transmit intervals and receive-monitoring timeouts in milliseconds
// ----------------------------------------------------------------------------
`define PCL_TX_200_MS     12'h0c8
`define PCL_TX_100_MS     12'h064
`define PCL_TX_50_MS      12'h032
`define PCL_RX_2400_MS    12'h960
`define PCL_RX_1200_MS    12'h4b0
`define PCL_RX_600_MS     12'h258

// ----------------------------------------------------------------------------
// Switch bank field positions (bit 0 is switch position 1)
// ----------------------------------------------------------------------------
`define PCL_SW_BAUD       0
`define PCL_SW_IVL_A      1
`define PCL_SW_IVL_B      2
`define PCL_SW_ADDR_MSB   3
`define PCL_SW_ADDR_LSB   6
`define PCL_SW_FLAVOUR    7

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PCL_REG_CTRL      8'h00
`define PCL_REG_CONFIG    8'h04
`define PCL_REG_INT_STAT  8'h08
`define PCL_REG_INT_CLR   8'h0c
`define PCL_REG_INT_EN    8'h10
`define PCL_REG_TIMING    8'h14

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define PCL_CTRL_ENABLE   0
`define PCL_CTRL_RELOAD   1
`define PCL_CTRL_RESET    1'b1
`define PCL_EV_TX         0
`define PCL_EV_RX_TMO     1
`define PCL_EV_RX         2
`define PCL_EV_KEY        3
`define PCL_EV_WIDTH      4
`define PCL_INT_EN_RESET  4'h0
`define PCL_CAP_SETTLE    2'h3

`endif

/* File: rtl/pcl_pkg.sv */
// Types and decode functions of the panel link configuration block.
// Assumes pcl_defs.svh is on the include path.
`include "pcl_defs.svh"

package pcl_pkg;

    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        PCL_IVL_200 = 3'b001,
        PCL_IVL_100 = 3'b010,
        PCL_IVL_50  = 3'b100
    } pcl_interval_e;

    typedef logic [2:0]  pcl_gd_set_t;
    typedef logic [3:0]  pcl_addr_t;
    typedef logic [11:0] pcl_ms_t;

    // ------------------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------------------
    // Switch 2 on alone gives 200 ms, switch 3 on alone 100 ms, both off 50 ms.
    // Both on is undefined and falls back to the lightest bus load.
    function automatic pcl_interval_e interval_of(input logic [7:0] sw);
        if (sw[`PCL_SW_IVL_B] && !sw[`PCL_SW_IVL_A])
            return PCL_IVL_100;
        else if (!sw[`PCL_SW_IVL_B] && !sw[`PCL_SW_IVL_A])
            return PCL_IVL_50;
        else
            return PCL_IVL_200;
    endfunction : interval_of

    // Switch position 4 is the address MSB, position 7 the LSB.
    function automatic pcl_addr_t addr_of(input logic [7:0] sw);
        return {sw[3], sw[4], sw[5], sw[6]};
    endfunction : addr_of

    // Parameter set per address; zero marks a reserved address.
    function automatic pcl_gd_set_t gd_set_of(input pcl_addr_t a);
        unique case (a)
            4'h4, 4'h5:       return 3'h5;
            4'h7, 4'h8:       return 3'h4;
            4'h9, 4'ha:       return 3'h3;
            4'hb, 4'hc:       return 3'h2;
            4'hd, 4'he, 4'hf: return 3'h1;
            default:          return 3'h0;
        endcase
    endfunction : gd_set_of

endpackage : pcl_pkg

/* File: rtl/pcl_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous pin levels.
// Assumes each bit is an independent slow level such as a switch or key.
`timescale 1ns/1ps

module pcl_sync
(
    // Clock and reset.
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    // Asynchronous levels in, synchronised levels out.
    input  wire logic [8:0] i_async,
    output logic      [8:0] o_sync
);

    logic [8:0] meta_q;
    logic [8:0] sync_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            meta_q <= 9'h000;
            sync_q <= 9'h000;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule : pcl_sync

/* File: rtl/pcl_timer.sv */
// Millisecond interval timer that fires a pulse every i_limit ticks.
// Assumes i_tick is a one-cycle pulse once per millisecond.
`timescale 1ns/1ps

module pcl_timer
(
    // Clock and reset.
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    // Time base and control.
    input  wire logic             i_tick,
    input  wire logic             i_restart,
    input  wire pcl_pkg::pcl_ms_t i_limit,
    // Expiry pulse.
    output logic                  o_expired
);
    import pcl_pkg::*;

    pcl_ms_t cnt_q;
    pcl_ms_t cnt_d;
    logic    hit;

    // A restart wins over a tick so the period always starts afresh.
    assign hit   = i_tick && (cnt_q >= i_limit - 12'h001);
    assign cnt_d = i_restart ? 12'h000 : hit ? 12'h000 : i_tick ? cnt_q + 12'h001 : cnt_q;

    // Counter and expiry register.
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            cnt_q     <= 12'h000;
            o_expired <= 1'b0;
        end
        else
        begin
            cnt_q     <= cnt_d;
            o_expired <= hit && !i_restart;
        end
    end

endmodule : pcl_timer

/* File: rtl/pcl_top.sv */
// Configuration decode and frame cadence of a control panel bus node.
// Assumes an APB master on i_clk, pins arriving asynchronously, and a frame
// engine on i_clk that sends a frame on o_tx_frame and flags each received one.
//
// Functional notes
// - Switch 1 on selects 1.5 Mbaud, off selects 187.5 kBaud.
// - Switches 2 and 3 select 200, 100 or 50 ms transmit interval.
// - Receive timeout follows interval: 2400, 1200 or 600 ms.
// - Switches 4 to 7 give station address 0 to 15.
// - Switch 8 on selects customer panel port, off series hardware.
// - With no key pressed, frames go out at the selected interval.
// - Controller frames arrive periodically and are watched against the timeout.
// - No exchange until parameters matching the address are active.
// - Address picks parameter set; 0 to 3 and 6 reserved.
`timescale 1ns/1ps
`include "pcl_defs.svh"

module pcl_top
#(
    parameter int P_CYC_PER_MS = `PCL_CYC_PER_MS
)
(
    // Clock and reset.
    input  wire logic                 i_clk,
    input  wire logic                 i_reset,
    // APB slave.
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [7:0]           i_paddr,
    input  wire logic [31:0]          i_pwdata,
    output logic                      o_pready,
    output logic      [31:0]          o_prdata,
    output logic                      o_pslverr,
    // Asynchronous pins.
    input  wire logic [7:0]           i_cfg_switch_bank,
    input  wire logic                 i_key_pressed,
    // Frame engine.
    input  wire logic                 i_rx_frame,
    output logic                      o_tx_frame,
    output logic                      o_tx_key_event,
    // Decoded configuration.
    output logic                      o_baud_fast,
    output logic                      o_cust_panel,
    output pcl_pkg::pcl_addr_t        o_station_addr,
    output pcl_pkg::pcl_gd_set_t      o_gd_set,
    output logic                      o_exchange_enable,
    // Interrupt.
    output logic                      o_irq
);
    import pcl_pkg::*;

    // ------------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------------
    logic [8:0] pin_sync;
    logic [7:0] sw_sync;
    logic       key_sync;
    logic       key_prev_q;
    logic       key_rise;

    pcl_sync u_sync
    (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async ({i_key_pressed, i_cfg_switch_bank}),
        .o_sync  (pin_sync)
    );

    // Split the synchronised bundle and find a new key press.
    assign sw_sync  = pin_sync[7:0];
    assign key_sync = pin_sync[8];
    assign key_rise = key_sync && !key_prev_q;

    // ------------------------------------------------------------------------
    // Switch capture
    // ------------------------------------------------------------------------
    logic [1:0]    cap_cnt_q;
    logic          cfg_load;
    logic          reload_wr;
    logic [7:0]    cfg_q;
    logic          cfg_valid_q;
    pcl_gd_set_t   gd_q;
    pcl_interval_e ivl;
    pcl_ms_t       tx_ms;
    pcl_ms_t       rx_ms;

    // The bank is caught once the synchroniser has settled after reset, and
    // again on a software reload, so a half-moved switch never steers traffic.
    assign cfg_load = (cap_cnt_q == 2'h1) || reload_wr;

    // Interval choice and the timeout tied to it.
    assign ivl   = interval_of(cfg_q);
    assign tx_ms = (ivl == PCL_IVL_200) ? `PCL_TX_200_MS :
                   (ivl == PCL_IVL_100) ? `PCL_TX_100_MS : `PCL_TX_50_MS;
    assign rx_ms = (ivl == PCL_IVL_200) ? `PCL_RX_2400_MS :
                   (ivl == PCL_IVL_100) ? `PCL_RX_1200_MS : `PCL_RX_600_MS;

    // Capture counter and captured configuration.
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            cap_cnt_q   <= `PCL_CAP_SETTLE;
            cfg_q       <= 8'h00;
            gd_q        <= 3'h0;
            cfg_valid_q <= 1'b0;
            key_prev_q  <= 1'b0;
        end
        else
        begin
            key_prev_q <= key_sync;
            if (cap_cnt_q != 2'h0)
                cap_cnt_q <= cap_cnt_q - 2'h1;
            if (cfg_load)
            begin
                cfg_q       <= sw_sync;
                gd_q        <= gd_set_of(addr_of(sw_sync));
                cfg_valid_q <= 1'b1;
            end
        end
    end

    // Decoded configuration outputs straight from the captured bank.
    assign o_baud_fast    = cfg_q[`PCL_SW_BAUD];
    assign o_station_addr = addr_of(cfg_q);
    assign o_cust_panel   = cfg_q[`PCL_SW_FLAVOUR];
    assign o_gd_set       = gd_q;

    // ------------------------------------------------------------------------
    // Millisecond time base
    // ------------------------------------------------------------------------
    logic [16:0] div_q;
    logic        ms_tick;

    assign ms_tick = (div_q == 17'(P_CYC_PER_MS - 1));

    // Divider from the system clock to one enable pulse per millisecond.
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            div_q <= 17'h0_0000;
        else if (ms_tick)
            div_q <= 17'h0_0000;
        else
            div_q <= div_q + 17'h0_0001;
    end

    // ------------------------------------------------------------------------
    // Frame cadence and receive monitoring
    // ------------------------------------------------------------------------
    logic ctrl_enable_q;
    logic exch_ok;
    logic exch_q;
    logic tx_expired;
    logic rx_expired;
    logic tx_fire;

    // Exchange needs a captured bank, an enabled block and a live parameter set.
    assign exch_ok = cfg_valid_q && ctrl_enable_q && (gd_q != 3'h0);
    assign tx_fire = exch_ok && (tx_expired || key_rise);

    pcl_timer u_tx_timer
    (
        .i_clk     (i_clk),
        .i_reset   (i_reset),
        .i_tick    (ms_tick),
        .i_restart (tx_fire || !exch_ok),
        .i_limit   (tx_ms),
        .o_expired (tx_expired)
    );

    pcl_timer u_rx_timer
    (
        .i_clk     (i_clk),
        .i_reset   (i_reset),
        .i_tick    (ms_tick),
        .i_restart (i_rx_frame || !exch_ok),
        .i_limit   (rx_ms),
        .o_expired (rx_expired)
    );

    // Frame request and its reason, registered.
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_tx_frame     <= 1'b0;
            o_tx_key_event <= 1'b0;
            exch_q         <= 1'b0;
        end
        else
        begin
            o_tx_frame     <= tx_fire;
            o_tx_key_event <= exch_ok && key_rise;
            exch_q         <= exch_ok;
        end
    end

    assign o_exchange_enable = exch_q;

    // ------------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------------
    logic [3:0] events;
    logic [3:0] int_stat_q;
    logic [3:0] int_en_q;
    logic [3:0] clr_mask;
    logic       clr_wr;

    assign events[`PCL_EV_TX]     = tx_fire;
    assign events[`PCL_EV_RX_TMO] = exch_ok && rx_expired;
    assign events[`PCL_EV_RX]     = exch_ok && i_rx_frame;
    assign events[`PCL_EV_KEY]    = exch_ok && key_rise;
    assign clr_mask = clr_wr ? i_pwdata[3:0] : 4'h0;

    // A new event wins over a clear in the same cycle.
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            int_stat_q <= 4'h0;
        else
            int_stat_q <= (int_stat_q & ~clr_mask) | events;
    end

    assign o_irq = |(int_stat_q & int_en_q);

    // ------------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------------
    logic        setup;
    logic        wr_access;
    logic        hit_ctrl;
    logic        hit_cfg;
    logic        hit_stat;
    logic        hit_clr;
    logic        hit_en;
    logic        hit_tim;
    logic        mapped;
    logic [31:0] rd_mux;

    // Address decode, one aligned word per register.
    assign setup     = i_psel && !i_penable;
    assign wr_access = i_psel && i_penable && i_pwrite;
    assign hit_ctrl  = (i_paddr == `PCL_REG_CTRL);
    assign hit_cfg   = (i_paddr == `PCL_REG_CONFIG);
    assign hit_stat  = (i_paddr == `PCL_REG_INT_STAT);
    assign hit_clr   = (i_paddr == `PCL_REG_INT_CLR);
    assign hit_en    = (i_paddr == `PCL_REG_INT_EN);
    assign hit_tim   = (i_paddr == `PCL_REG_TIMING);
    assign mapped    = hit_ctrl || hit_cfg || hit_stat || hit_clr || hit_en || hit_tim;
    assign reload_wr = wr_access && hit_ctrl && i_pwdata[`PCL_CTRL_RELOAD];
    assign clr_wr    = wr_access && hit_clr;

    // Read data selection; the clear register reads as zero.
    assign rd_mux = hit_ctrl ? {31'h0000_0000, ctrl_enable_q} :
                    hit_cfg  ? {13'h0000, exch_q, cfg_valid_q, o_cust_panel, o_baud_fast,
                                gd_q, o_station_addr, cfg_q} :
                    hit_stat ? {28'h000_0000, int_stat_q} :
                    hit_en   ? {28'h000_0000, int_en_q} :
                    hit_tim  ? {4'h0, rx_ms, 4'h0, tx_ms} : 32'h0000_0000;

    // Zero-wait answer; read data is latched during the setup cycle.
    assign o_pready = 1'b1;

    // Writable registers and the registered bus answer.
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            ctrl_enable_q <= `PCL_CTRL_RESET;
            int_en_q      <= `PCL_INT_EN_RESET;
            o_prdata      <= 32'h0000_0000;
            o_pslverr     <= 1'b0;
        end
        else
        begin
            if (setup)
            begin
                o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_mux;
                o_pslverr <= !mapped;
            end
            if (wr_access && hit_ctrl)
                ctrl_enable_q <= i_pwdata[`PCL_CTRL_ENABLE];
            if (wr_access && hit_en)
                int_en_q <= i_pwdata[3:0];
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_key_fire;
        key_rise && exch_ok;
    endsequence

    sequence s_frame_out;
        o_tx_frame && o_tx_key_event;
    endsequence

    sequence s_periodic;
        tx_expired && exch_ok;
    endsequence

    a_baud_capture: assert property (cfg_load |=> o_baud_fast == $past(sw_sync[0]))
        else $error("Baud selection does not follow switch one.");

    a_interval_map: assert property (tx_ms == ((!cfg_q[2] && cfg_q[1]) ? 12'h0c8 :
        (cfg_q[2] && !cfg_q[1]) ? 12'h064 : (!cfg_q[2] && !cfg_q[1]) ? 12'h032 : 12'h0c8))
        else $error("Transmit interval decode is wrong.");

    a_timeout_ratio: assert property (rx_ms == 12'(tx_ms * 12'h00c))
        else $error("Receive timeout is not twelve intervals.");

    a_addr_order: assert property (cfg_load |=> o_station_addr ==
        {$past(sw_sync[3]), $past(sw_sync[4]), $past(sw_sync[5]), $past(sw_sync[6])})
        else $error("Station address bit order is wrong.");

    a_flavour_pick: assert property (cfg_load |=> o_cust_panel == $past(sw_sync[7]))
        else $error("Interface flavour does not follow switch eight.");

    a_tx_gated: assert property (o_tx_frame |-> $past(exch_ok) && $past(gd_q) != 3'h0)
        else $error("Frame sent without active parameters.");

    a_gd_reserved: assert property (##1 o_station_addr == 4'h6 && $stable(cfg_q)
        |-> o_gd_set == 3'h0 ##1 !o_exchange_enable)
        else $error("Reserved address gained a parameter set.");

    a_key_frame: assert property (s_key_fire |=> s_frame_out)
        else $error("Key press did not send an event frame.");

    a_periodic_tx: assert property (s_periodic |=> o_tx_frame ##1 (!o_tx_frame || o_tx_key_event))
        else $error("Interval expiry did not send one frame.");

    a_rx_timeout: assert property (rx_expired && exch_ok |=> int_stat_q[1] ##1 (int_stat_q[1] || $past(clr_mask[1])))
        else $error("Receive timeout not flagged.");

endmodule : pcl_top

/* File: verif/pcl_plc_model.sv */
// Controller-side model that sends frames to the panel and watches its cadence.
// Assumes the panel's clock and one-cycle frame pulses in both directions.
`timescale 1ns/1ps

module pcl_plc_model
#(
    parameter int P_RX_PERIOD = 300,
    parameter int P_MAX_GAP   = 5000
)
(
    // Clock and reset.
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // Link traffic.
    input  wire logic        i_run,
    input  wire logic        i_tx_frame,
    output logic             o_rx_frame,
    // Observations.
    output logic      [15:0] o_frames,
    output logic             o_late
);
    int cnt_q;
    int gap_q;

    // Sends one frame pulse every P_RX_PERIOD cycles while running.
    always_ff @(posedge i_clk)
    begin
        if (i_reset || !i_run || cnt_q == P_RX_PERIOD - 1)
            cnt_q <= 0;
        else
            cnt_q <= cnt_q + 1;
        o_rx_frame <= !i_reset && i_run && cnt_q == P_RX_PERIOD - 1;
    end

    // Counts panel frames and, once the first has arrived, flags any silence longer than the allowed gap.
    always_ff @(posedge i_clk)
    begin
        if (i_reset || i_tx_frame)
            gap_q <= 0;
        else
            gap_q <= gap_q + 1;
        if (i_reset)
            o_frames <= '0;
        else if (i_tx_frame)
            o_frames <= o_frames + 16'h0001;
        if (i_reset)
            o_late <= 1'b0;
        else if (o_frames != 16'h0000 && gap_q > P_MAX_GAP)
            o_late <= 1'b1;
    end
endmodule : pcl_plc_model

/* File: verif/tb.sv */
// Self-checking bench of the panel link block with a controller model.
// Assumes one millisecond is shortened to 10 clock cycles.
`timescale 1ns/1ps

module tb;
    import pcl_pkg::*;
    typedef struct {logic [7:0] sw; logic [3:0] adr; logic [2:0] gd; logic [11:0] tx; logic [11:0] rx; logic bd; logic cp;} pcl_row_s;
    logic clk, rst, psel, pen, pwr, key, run, pready, pslverr, rxf, txf, kev, baud, cust, exch, irq, late, perr;
    logic [7:0] paddr, sw;
    logic [31:0] pwdata, prdata, prd;
    logic [15:0] frames, n;
    pcl_addr_t adr;
    pcl_gd_set_t gd;
    int n_fail, samples_checked, cyc, c;
    pcl_row_s rows[8] = '{
        '{8'h35, 4'h6, 3'h0, 12'h064, 12'h4b0, 1'b1, 1'b0}, '{8'h8a, 4'h8, 3'h4, 12'h0c8, 12'h960, 1'b0, 1'b1},
        '{8'h51, 4'h5, 3'h5, 12'h032, 12'h258, 1'b1, 1'b0}, '{8'h7c, 4'hf, 3'h1, 12'h064, 12'h4b0, 1'b0, 1'b0},
        '{8'h48, 4'h9, 3'h3, 12'h032, 12'h258, 1'b0, 1'b0}, '{8'h68, 4'hb, 3'h2, 12'h032, 12'h258, 1'b0, 1'b0},
        '{8'h07, 4'h0, 3'h0, 12'h0c8, 12'h960, 1'b1, 1'b0}, '{8'h72, 4'h7, 3'h4, 12'h0c8, 12'h960, 1'b0, 1'b0}};

    pcl_top #(.P_CYC_PER_MS(10)) dut (.i_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .i_cfg_switch_bank(sw), .i_key_pressed(key), .i_rx_frame(rxf), .o_tx_frame(txf), .o_tx_key_event(kev),
        .o_baud_fast(baud), .o_cust_panel(cust), .o_station_addr(adr), .o_gd_set(gd), .o_exchange_enable(exch),
        .o_irq(irq));
    pcl_plc_model plc (.i_clk(clk), .i_reset(rst), .i_run(run), .i_tx_frame(txf), .o_rx_frame(rxf),
        .o_frames(frames), .o_late(late));

    // Clock of 8 ns and a cycle ceiling that cuts a hang short.
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            stop_test();
        end
    end

    // Compares a value and counts the outcome.
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // One APB transfer; read data and error are taken at the completing edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        prd = prdata;
        perr = pslverr;
        psel <= 1'b0; pen <= 1'b0;
    endtask : apb

    // Reads a register and compares it.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(prd, e);
    endtask : rd_chk

    // Sets the switch bank and resets the block for 2 cycles so it is captured.
    task automatic cfg(input logic [7:0] s);
        sw <= s; rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : cfg

    // Counts cycles until the next frame request, bounded.
    task automatic wait_tx(output int k);
        k = 0;
        do begin @(posedge clk); k++; end while (txf !== 1'b1 && k < 3000);
    endtask : wait_tx

    // Prints counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checked=%0d failed=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    // Main sequence: table of switch settings, then hand-written cases.
    initial
    begin
        rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
        sw = 8'h00; key = 1'b0; run = 1'b1;
        foreach (rows[i])
        begin
            cfg(rows[i].sw);
            chk(baud, rows[i].bd);
            chk(cust, rows[i].cp);
            chk(adr, rows[i].adr);
            chk(gd, rows[i].gd);
            chk(exch, rows[i].gd != 3'h0);
            rd_chk(8'h14, {4'h0, rows[i].rx, 4'h0, rows[i].tx});
        end
        cfg(8'h51);
        rd_chk(8'h00, 32'h0000_0001);
        rd_chk(8'h10, 32'h0000_0000);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk(perr, 1'b1);
        chk(prd, 32'h0000_0000);
        wait_tx(c);
        wait_tx(c);
        chk(c >= 488 && c <= 502, 1'b1);
        repeat (100) @(posedge clk);
        key <= 1'b1;
        wait_tx(c);
        chk({c <= 8, kev}, 2'b11);
        key <= 1'b0;
        wait_tx(c);
        chk(c >= 488 && c <= 502, 1'b1);
        do @(posedge clk); while (rxf !== 1'b1);
        run <= 1'b0;
        apb(1'b1, 8'h10, 32'h0000_0002);
        repeat (5880) @(posedge clk);
        chk(irq, 1'b0);
        repeat (150) @(posedge clk);
        chk(irq, 1'b1);
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk(prd, 32'h0000_000f);
        apb(1'b1, 8'h10, 32'h0000_0000);
        @(posedge clk);
        chk(irq, 1'b0);
        apb(1'b1, 8'h10, 32'h0000_0002);
        @(posedge clk);
        chk(irq, 1'b1);
        apb(1'b1, 8'h0c, 32'h0000_0002);
        @(posedge clk);
        chk(irq, 1'b0);
        chk(late, 1'b0);
        apb(1'b1, 8'h00, 32'h0000_0000);
        repeat (3) @(posedge clk);
        chk(exch, 1'b0);
        n = frames;
        repeat (700) @(posedge clk);
        chk(frames, n);
        run <= 1'b1;
        cfg(8'h35);
        n = frames;
        repeat (1100) @(posedge clk);
        chk(frames, n);
        chk({baud, adr, cust}, {1'b1, 4'h6, 1'b0});
        // A live switch change is only taken over by a software reload.
        sw <= 8'h51;
        repeat (3) @(posedge clk);
        apb(1'b1, 8'h00, 32'h0000_0003);
        repeat (3) @(posedge clk);
        chk({adr, gd, exch}, {4'h5, 3'h5, 1'b1});
        stop_test();
    end
endmodule : tb
